// [logic/uart_modem_ctrl.sv]
// modem control, user outputs, request-to-send and loopback of a serial port
//
// Overview of operation
// - loopback, normal: tx pin high, tx looped
// - interrupts work unchanged during loopback
// - loopback: modem inputs replaced by control outputs
// - loopback: output b high, bit looped back
// - loopback: output a high, bit looped back
// - no auto flow: request pin is inverse bit 1
// - auto flow: above threshold forces request high
// - loopback: request pin high, bit looped back
// - control bits read/write, reset to zero
// - bit 6 selects infrared or normal mode
// - bit 5 enables auto flow with fifos
`include "uart_modem_ctrl_defines.svh"
`default_nettype none
module uart_modem_ctrl (
   // clock and reset
   input  wire logic                              SYS_CLK_IN,
   input  wire logic                              RST_N_IN,
   // register port
   input  wire uart_modem_ctrl_pkg::reg_addr_type REG_ADDR_IN,
   input  wire uart_modem_ctrl_pkg::reg_data_type REG_WDATA_IN,
   input  wire logic                              REG_WR_IN,
   input  wire logic                              REG_RD_IN,
   output var  uart_modem_ctrl_pkg::reg_data_type REG_RDATA_OUT,
   // interrupt
   output logic                                   IRQ_OUT,
   // neighbouring blocks of the port
   input  wire logic                              FIFO_EN_IN,
   input  wire logic                              RX_ABOVE_TRIG_IN,
   input  wire uart_modem_ctrl_pkg::line_status_type LINE_STATUS_IN,
   input  wire logic                              TX_SER_IN,
   input  wire logic                              IR_TX_N_IN,
   output logic                                   RX_SER_OUT,
   output logic                                   IR_RX_OUT,
   output var  uart_modem_ctrl_pkg::modem_line_type MODEM_STAT_OUT,
   output logic                                   IR_MODE_OUT,
   // serial data pins
   output logic                                   SER_TX_OUT,
   input  wire logic                              SER_RX_IN,
   output logic                                   IR_TX_N_OUT,
   input  wire logic                              IR_RX_IN,
   // modem pins, active low
   output logic                                   DTR_N_OUT,
   output logic                                   RTS_N_OUT,
   output logic                                   USER_OUTPUT_A_PIN_N_OUT,
   output logic                                   USER_OUTPUT_B_PIN_N_OUT,
   input  wire logic                              CTS_N_IN,
   input  wire logic                              DSR_N_IN,
   input  wire logic                              RING_INDICATE_PIN_N_IN,
   input  wire logic                              DCD_N_IN
);
   import uart_modem_ctrl_pkg::*;

   logic [`MCTL_WIDTH-1:0] modem_control_reg_r;
   logic                  loopback_select;
   logic                  infrared_enable_bit;
   logic                  auto_flow_enable_bit;
   logic                  user_output_a_ctl;
   logic                  user_output_b_ctl;
   logic                  rts_ctl;
   logic                  dtr_ctl;
   logic                  rts_gated;
   modem_line_type        mstat_nxt;
   modem_line_type        mstat_r;
   modem_line_type        mevent;
   modem_line_type        istat_r;
   modem_line_type        imask_r;
   modem_line_type        istat_clr;
   logic                  wr_mctl;
   logic                  wr_istat;
   logic                  wr_imask;
   reg_data_type          rdata_nxt;

   // write decode
   assign wr_mctl  = REG_WR_IN && (REG_ADDR_IN == `MODEM_LINE_CONTROL_OFS);
   assign wr_istat = REG_WR_IN && (REG_ADDR_IN == `MODEM_IRQ_STATUS_OFS);
   assign wr_imask = REG_WR_IN && (REG_ADDR_IN == `MODEM_IRQ_MASK_OFS);

   // modem control register, cleared at reset
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         modem_control_reg_r <= `MCTL_RESET;
      end else if (wr_mctl) begin
         modem_control_reg_r <= REG_WDATA_IN[`MCTL_WIDTH-1:0];
      end
   end

   // field views of the control register
   assign dtr_ctl              = modem_control_reg_r[`MCTL_DTR_BIT];
   assign rts_ctl              = modem_control_reg_r[`MCTL_RTS_BIT];
   assign user_output_a_ctl    = modem_control_reg_r[`MCTL_OUT_A_BIT];
   assign user_output_b_ctl    = modem_control_reg_r[`MCTL_OUT_B_BIT];
   assign loopback_select      = modem_control_reg_r[`MCTL_LOOP_BIT];
   assign auto_flow_enable_bit = modem_control_reg_r[`MCTL_AFLOW_BIT];
   assign infrared_enable_bit  = modem_control_reg_r[`MCTL_IR_BIT];

   // request-to-send qualified by the receive threshold under auto flow
   assign rts_gated = rts_ctl &&
      !(auto_flow_enable_bit && FIFO_EN_IN && RX_ABOVE_TRIG_IN);

   // modem status as seen by the port, looped in diagnostic mode
   always_comb begin
      if (loopback_select) begin
         mstat_nxt[`MLS_CTS_BIT] = rts_ctl;
         mstat_nxt[`MLS_DSR_BIT] = dtr_ctl;
         mstat_nxt[`MLS_RI_BIT]  = user_output_a_ctl;
         mstat_nxt[`MLS_DCD_BIT] = user_output_b_ctl;
      end else begin
         mstat_nxt[`MLS_CTS_BIT] = !CTS_N_IN;
         mstat_nxt[`MLS_DSR_BIT] = !DSR_N_IN;
         mstat_nxt[`MLS_RI_BIT]  = !RING_INDICATE_PIN_N_IN;
         mstat_nxt[`MLS_DCD_BIT] = !DCD_N_IN;
      end
   end

   // modem status register
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         mstat_r <= `IRQ_RESET;
      end else begin
         mstat_r <= mstat_nxt;
      end
   end

   // change events: any edge, ring only on its trailing edge
   always_comb begin
      mevent = mstat_nxt ^ mstat_r;
      mevent[`MLS_RI_BIT] = mstat_r[`MLS_RI_BIT] && !mstat_nxt[`MLS_RI_BIT];
   end

   // write-one-to-clear mask
   assign istat_clr = wr_istat ? REG_WDATA_IN[3:0] : 4'h0;

   // sticky interrupt status, a new event beats a clear
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         istat_r <= `IRQ_RESET;
      end else begin
         istat_r <= (istat_r & ~istat_clr) | mevent;
      end
   end

   // interrupt mask
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         imask_r <= `IRQ_RESET;
      end else if (wr_imask) begin
         imask_r <= REG_WDATA_IN[3:0];
      end
   end

   // interrupt output, high while any unmasked status bit is set
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         IRQ_OUT <= 1'b0;
      end else begin
         IRQ_OUT <= |(istat_r & imask_r);
      end
   end

   // read multiplexer, unmapped addresses read zero
   always_comb begin
      rdata_nxt = `RDATA_RESET;
      unique case (REG_ADDR_IN)
         `MODEM_LINE_CONTROL_OFS:
            rdata_nxt[`MCTL_WIDTH-1:0] = modem_control_reg_r;
         `LINE_CONDITION_STATUS_OFS:
            rdata_nxt[7:0] = LINE_STATUS_IN;
         `MODEM_LINE_STATUS_OFS:
            rdata_nxt[3:0] = mstat_r;
         `MODEM_IRQ_STATUS_OFS:
            rdata_nxt[3:0] = istat_r;
         `MODEM_IRQ_MASK_OFS:
            rdata_nxt[3:0] = imask_r;
         default:
            rdata_nxt = `RDATA_RESET;
      endcase
   end

   // read data stand for the one cycle after the strobe
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         REG_RDATA_OUT <= `RDATA_RESET;
      end else if (REG_RD_IN) begin
         REG_RDATA_OUT <= rdata_nxt;
      end else begin
         REG_RDATA_OUT <= `RDATA_RESET;
      end
   end

   // serial data path, normal or looped
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         SER_TX_OUT  <= 1'b1;
         RX_SER_OUT  <= 1'b1;
         IR_TX_N_OUT <= 1'b1;
         IR_RX_OUT   <= 1'b0;
      end else if (loopback_select && !infrared_enable_bit) begin
         SER_TX_OUT  <= 1'b1;
         RX_SER_OUT  <= TX_SER_IN;
         IR_TX_N_OUT <= 1'b1;
         IR_RX_OUT   <= IR_RX_IN;
      end else if (loopback_select) begin
         SER_TX_OUT  <= 1'b1;
         RX_SER_OUT  <= SER_RX_IN;
         IR_TX_N_OUT <= 1'b0;
         IR_RX_OUT   <= !TX_SER_IN;
      end else begin
         SER_TX_OUT  <= TX_SER_IN;
         RX_SER_OUT  <= SER_RX_IN;
         IR_TX_N_OUT <= IR_TX_N_IN;
         IR_RX_OUT   <= IR_RX_IN;
      end
   end

   // modem outputs, held inactive high during loopback
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         DTR_N_OUT               <= 1'b1;
         RTS_N_OUT               <= 1'b1;
         USER_OUTPUT_A_PIN_N_OUT <= 1'b1;
         USER_OUTPUT_B_PIN_N_OUT <= 1'b1;
      end else if (loopback_select) begin
         DTR_N_OUT               <= 1'b1;
         RTS_N_OUT               <= 1'b1;
         USER_OUTPUT_A_PIN_N_OUT <= 1'b1;
         USER_OUTPUT_B_PIN_N_OUT <= 1'b1;
      end else begin
         DTR_N_OUT               <= !dtr_ctl;
         RTS_N_OUT               <= !rts_gated;
         USER_OUTPUT_A_PIN_N_OUT <= !user_output_a_ctl;
         USER_OUTPUT_B_PIN_N_OUT <= !user_output_b_ctl;
      end
   end

   // status copies for the rest of the port
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         MODEM_STAT_OUT <= `IRQ_RESET;
         IR_MODE_OUT    <= 1'b0;
      end else begin
         MODEM_STAT_OUT <= mstat_nxt;
         IR_MODE_OUT    <= infrared_enable_bit;
      end
   end

   // checks
   property p_lb_tx_high;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (loopback_select && !infrared_enable_bit) |=>
         (SER_TX_OUT && RX_SER_OUT == $past(TX_SER_IN));
   endproperty
   a_lb_tx_high: assert property (p_lb_tx_high)
      else $error("loopback did not hold tx high or loop data");

   property p_lb_irq;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (loopback_select && mevent[`MLS_CTS_BIT]) |=>
         istat_r[`MLS_CTS_BIT] ##1
         (!$past(imask_r[`MLS_CTS_BIT]) || IRQ_OUT);
   endproperty
   a_lb_irq: assert property (p_lb_irq)
      else $error("modem change in loopback lost its interrupt");

   property p_lb_status;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      loopback_select |=> MODEM_STAT_OUT ==
         $past({user_output_b_ctl, user_output_a_ctl, dtr_ctl, rts_ctl});
   endproperty
   a_lb_status: assert property (p_lb_status)
      else $error("loopback status not taken from control bits");

   property p_lb_ir;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (loopback_select && infrared_enable_bit) |=>
         (!IR_TX_N_OUT && IR_RX_OUT == !$past(TX_SER_IN));
   endproperty
   a_lb_ir: assert property (p_lb_ir)
      else $error("infrared loopback wrong");

   property p_out_b;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      !loopback_select |=>
         USER_OUTPUT_B_PIN_N_OUT == !$past(user_output_b_ctl);
   endproperty
   a_out_b: assert property (p_out_b)
      else $error("user output b not inverse of its bit");

   property p_out_a;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      !loopback_select |=>
         USER_OUTPUT_A_PIN_N_OUT == !$past(user_output_a_ctl);
   endproperty
   a_out_a: assert property (p_out_a)
      else $error("user output a not inverse of its bit");

   property p_lb_pins_high;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      loopback_select [*2] |->
         (USER_OUTPUT_A_PIN_N_OUT && USER_OUTPUT_B_PIN_N_OUT && RTS_N_OUT);
   endproperty
   a_lb_pins_high: assert property (p_lb_pins_high)
      else $error("modem pin active during loopback");

   property p_rts_plain;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (!loopback_select && !auto_flow_enable_bit) |=>
         RTS_N_OUT == !$past(rts_ctl);
   endproperty
   a_rts_plain: assert property (p_rts_plain)
      else $error("request pin not inverse of its bit");

   property p_rts_flow;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (!loopback_select && auto_flow_enable_bit && FIFO_EN_IN
         && RX_ABOVE_TRIG_IN) |=> RTS_N_OUT;
   endproperty
   a_rts_flow: assert property (p_rts_flow)
      else $error("request pin active above threshold");

   property p_reset_clear;
      @(posedge SYS_CLK_IN)
      !RST_N_IN |=> (modem_control_reg_r == `MCTL_RESET && RTS_N_OUT);
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("control bits not cleared by reset");

   property p_ctl_readback;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (wr_mctl ##1 (REG_RD_IN && REG_ADDR_IN == `MODEM_LINE_CONTROL_OFS
         && !REG_WR_IN)) |=>
         REG_RDATA_OUT[`MCTL_WIDTH-1:0] ==
         $past(REG_WDATA_IN[`MCTL_WIDTH-1:0], 2);
   endproperty
   a_ctl_readback: assert property (p_ctl_readback)
      else $error("control register readback mismatch");

endmodule // uart_modem_ctrl
`default_nettype wire

// [logic/uart_modem_ctrl_defines.svh]
// register offsets, field positions, reset values of the modem control block
`ifndef UART_MODEM_CTRL_DEFINES_SVH
`define UART_MODEM_CTRL_DEFINES_SVH

// register byte addresses
`define MODEM_LINE_CONTROL_OFS    32'h5000_1010
`define LINE_CONDITION_STATUS_OFS 32'h5000_1014
`define MODEM_LINE_STATUS_OFS     32'h5000_1018
`define MODEM_IRQ_STATUS_OFS      32'h5000_101C
`define MODEM_IRQ_MASK_OFS        32'h5000_1020

// modem control register fields
`define MCTL_DTR_BIT     0
`define MCTL_RTS_BIT     1
`define MCTL_OUT_A_BIT   2
`define MCTL_OUT_B_BIT   3
`define MCTL_LOOP_BIT    4
`define MCTL_AFLOW_BIT   5
`define MCTL_IR_BIT      6
`define MCTL_WIDTH       7

// modem line bit positions (status, interrupt and mask registers)
`define MLS_CTS_BIT      0
`define MLS_DSR_BIT      1
`define MLS_RI_BIT       2
`define MLS_DCD_BIT      3

// reset values
`define MCTL_RESET       7'h00
`define IRQ_RESET        4'h0
`define RDATA_RESET      16'h0000

`endif

// [logic/uart_modem_ctrl_pkg.sv]
// types shared by the modem control block
`default_nettype none
package uart_modem_ctrl_pkg;
   typedef logic [31:0] reg_addr_type;
   typedef logic [15:0] reg_data_type;
   typedef logic [3:0]  modem_line_type;
   typedef logic [7:0]  line_status_type;
endpackage
`default_nettype wire

// [dv/modem_partner.sv]
// behavioural modem on the far side of the serial and modem pins
`default_nettype none
module modem_partner (
   // clock and answer speed
   input  wire logic       clk_in,
   input  wire logic       slow_in,
   // ring and carrier from the phone line, {dcd, ri}, active low
   input  wire logic [1:0] line_cond_n_in,
   // pins from the port
   input  wire logic       ser_tx_in,
   input  wire logic       ir_tx_n_in,
   input  wire logic       dtr_n_in,
   input  wire logic       rts_n_in,
   // pins to the port
   output logic            ser_rx_out,
   output logic            ir_rx_out,
   output logic            cts_n_out,
   output logic            dsr_n_out,
   output logic            ring_n_out,
   output logic            dcd_n_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] rts_hist_r = 4'hF;
   logic       cts_n_r    = 1'b1;
   logic       dsr_n_r    = 1'b1;
   // clear-to-send answers request-to-send one cycle late, or five cycles late when slow
   always @(posedge clk_in) begin
      rts_hist_r <= {rts_hist_r[2:0], rts_n_in};
      cts_n_r    <= slow_in ? rts_hist_r[3] : rts_n_in;
      dsr_n_r    <= dtr_n_in;
   end
   // a loop plug echoes the data lines back
   assign cts_n_out  = cts_n_r;
   assign dsr_n_out  = dsr_n_r;
   assign ser_rx_out = ser_tx_in;
   assign ir_rx_out  = ~ir_tx_n_in;
   assign ring_n_out = line_cond_n_in[0];
   assign dcd_n_out  = line_cond_n_in[1];
endmodule // modem_partner
`default_nettype wire

// [dv/uart_modem_ctrl_tb_top.sv]
// self-checking bench of the modem control block
`include "uart_modem_ctrl_defines.svh"
`default_nettype none
module uart_modem_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import uart_modem_ctrl_pkg::*;
   logic            sys_clk = 1'b0;
   logic            rst_n   = 1'b0;
   reg_addr_type    addr    = 32'h0000_0000;
   reg_data_type    wdata   = 16'h0000;
   logic            wr = 1'b0, rd = 1'b0, fifo_en = 1'b0, above = 1'b0;
   logic            tx_ser = 1'b1, slow = 1'b0, ir_enc_n = 1'b1;
   logic [1:0]      line_n = 2'h3;
   line_status_type lstat  = 8'hA5;
   reg_data_type    rdata, d;
   modem_line_type  mstat;
   logic irq, rx_ser, ir_rx, ir_mode, ser_tx, ser_rx, ir_tx_n, ir_pin;
   logic dtr_n, rts_n, ua_n, ub_n, cts_n, dsr_n, ring_n, dcd_n;
   int   err_count = 0, compares = 0, cycles = 0;

   // clock
   always #2 sys_clk = ~sys_clk;

   uart_modem_ctrl uut (.SYS_CLK_IN(sys_clk), .RST_N_IN(rst_n),
      .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr),
      .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .IRQ_OUT(irq),
      .FIFO_EN_IN(fifo_en), .RX_ABOVE_TRIG_IN(above),
      .LINE_STATUS_IN(lstat), .TX_SER_IN(tx_ser), .IR_TX_N_IN(ir_enc_n),
      .RX_SER_OUT(rx_ser), .IR_RX_OUT(ir_rx), .MODEM_STAT_OUT(mstat),
      .IR_MODE_OUT(ir_mode), .SER_TX_OUT(ser_tx), .SER_RX_IN(ser_rx),
      .IR_TX_N_OUT(ir_tx_n), .IR_RX_IN(ir_pin), .DTR_N_OUT(dtr_n),
      .RTS_N_OUT(rts_n), .USER_OUTPUT_A_PIN_N_OUT(ua_n),
      .USER_OUTPUT_B_PIN_N_OUT(ub_n), .CTS_N_IN(cts_n), .DSR_N_IN(dsr_n),
      .RING_INDICATE_PIN_N_IN(ring_n), .DCD_N_IN(dcd_n));

   modem_partner modem (.clk_in(sys_clk), .slow_in(slow),
      .line_cond_n_in(line_n), .ser_tx_in(ser_tx), .ir_tx_n_in(ir_tx_n),
      .dtr_n_in(dtr_n), .rts_n_in(rts_n), .ser_rx_out(ser_rx),
      .ir_rx_out(ir_pin), .cts_n_out(cts_n), .dsr_n_out(dsr_n),
      .ring_n_out(ring_n), .dcd_n_out(dcd_n));

   // compare and count
   task automatic chk(input string what, input logic [15:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // register bus cycles
   task automatic wr_reg(input reg_addr_type a, input reg_data_type v);
      @(posedge sys_clk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input reg_addr_type a, output reg_data_type v);
      @(posedge sys_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   // write then read in the very next cycle, no gap between strobes
   task automatic wr_rd_reg(input reg_addr_type a, input reg_data_type v,
      output reg_data_type r);
      @(posedge sys_clk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 r = rdata;
   endtask
   task automatic settle;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask

   // reset values of bits and pins
   task automatic t_reset;
      rd_reg(`MODEM_LINE_CONTROL_OFS, d);
      chk("ctl", d, 16'h0000);
      chk("pin", {dtr_n, rts_n, ua_n, ub_n, ser_tx}, 16'h001F);
      chk("irq", irq, 16'h0000);
   endtask

   // read back and user outputs
   task automatic t_bits;
      wr_rd_reg(`MODEM_LINE_CONTROL_OFS, 16'h000E, d);
      chk("ctl", d, 16'h000E);
      settle();
      chk("rab", {rts_n, ua_n, ub_n}, 16'h0000);
      wr_reg(`MODEM_LINE_CONTROL_OFS, 16'h0004);
      settle();
      chk("rab", {rts_n, ua_n, ub_n}, 16'h0005);
      wr_reg(`MODEM_LINE_CONTROL_OFS, 16'h0008);
      settle();
      chk("rab", {rts_n, ua_n, ub_n}, 16'h0006);
      wr_reg(`MODEM_LINE_CONTROL_OFS, 16'hFFFF);
      rd_reg(`MODEM_LINE_CONTROL_OFS, d);
      chk("ctl", d, 16'h007F);
      wr_reg(`MODEM_LINE_CONTROL_OFS, 16'h0000);
   endtask

   // request-to-send gated by the receive threshold
   task automatic t_flow;
      fifo_en <= 1'b1;
      above   <= 1'b1;
      wr_reg(`MODEM_LINE_CONTROL_OFS, 16'h0022);
      settle();
      chk("rts", rts_n, 16'h0001);
      @(posedge sys_clk);
      above <= 1'b0;
      settle();
      chk("rts", rts_n, 16'h0000);
      @(posedge sys_clk);
      fifo_en <= 1'b0;
      above   <= 1'b1;
      settle();
      chk("rts", rts_n, 16'h0000);
      @(posedge sys_clk);
      fifo_en <= 1'b1;
      wr_reg(`MODEM_LINE_CONTROL_OFS, 16'h0002);
      settle();
      chk("rts", rts_n, 16'h0000);
      @(posedge sys_clk);
      fifo_en <= 1'b0;
      above   <= 1'b0;
   endtask

   // modem inputs, then loopback mapping of each output
   task automatic t_modem;
      logic [15:0] ctl [4] = '{16'h0011, 16'h0012, 16'h0014, 16'h0018};
      logic [15:0] exp [4] = '{16'h0002, 16'h0001, 16'h0004, 16'h0008};
      slow   <= 1'b1;
      line_n <= 2'h0;
      wr_reg(`MODEM_LINE_CONTROL_OFS, 16'h0003);
      repeat (8) @(posedge sys_clk);
      #1 chk("stat", mstat, 16'h000F);
      wr_reg(`MODEM_LINE_CONTROL_OFS, 16'h0010);
      settle();
      chk("stat", mstat, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         wr_reg(`MODEM_LINE_CONTROL_OFS, ctl[i]);
         settle();
         chk("stat", mstat, exp[i]);
         chk("pins", {dtr_n, rts_n, ua_n, ub_n}, 16'h000F);
         rd_reg(`MODEM_LINE_STATUS_OFS, d);
         chk("mls", d, exp[i]);
      end
      @(posedge sys_clk);
      line_n <= 2'h3;
      slow   <= 1'b0;
   endtask

   // serial and infrared data loops
   task automatic t_serial;
      wr_reg(`MODEM_LINE_CONTROL_OFS, 16'h0010);
      tx_ser <= 1'b0;
      settle();
      chk("loop", {ser_tx, rx_ser}, 16'h0002);
      @(posedge sys_clk);
      tx_ser <= 1'b1;
      settle();
      chk("loop", {ser_tx, rx_ser}, 16'h0003);
      wr_reg(`MODEM_LINE_CONTROL_OFS, 16'h0050);
      settle();
      chk("ir", {ir_tx_n, ir_rx, ir_mode}, 16'h0001);
      @(posedge sys_clk);
      tx_ser <= 1'b0;
      settle();
      chk("ir", {ir_tx_n, ir_rx, ir_mode}, 16'h0003);
      wr_reg(`MODEM_LINE_CONTROL_OFS, 16'h0000);
      ir_enc_n <= 1'b0;
      settle();
      chk("norm", {ser_tx, ir_mode}, 16'h0000);
      chk("pass", {rx_ser, ir_tx_n, ir_rx}, 16'h0001);
      @(posedge sys_clk);
      tx_ser   <= 1'b1;
      ir_enc_n <= 1'b1;
   endtask

   // interrupts during loopback, masking, clearing, other addresses
   task automatic t_irq;
      wr_reg(`MODEM_LINE_CONTROL_OFS, 16'h0010);
      settle();
      wr_reg(`MODEM_IRQ_STATUS_OFS, 16'h000F);
      wr_reg(`MODEM_IRQ_MASK_OFS, 16'h0001);
      settle();
      chk("irq", irq, 16'h0000);
      wr_reg(`MODEM_LINE_CONTROL_OFS, 16'h0012);
      settle();
      chk("irq", irq, 16'h0001);
      rd_reg(`MODEM_IRQ_STATUS_OFS, d);
      chk("ists", d, 16'h0001);
      wr_reg(`MODEM_IRQ_STATUS_OFS, 16'h0001);
      settle();
      chk("irq", irq, 16'h0000);
      wr_reg(`MODEM_IRQ_MASK_OFS, 16'h0000);
      wr_reg(`MODEM_LINE_CONTROL_OFS, 16'h0010);
      settle();
      chk("irq", irq, 16'h0000);
      rd_reg(`MODEM_IRQ_STATUS_OFS, d);
      chk("ists", d, 16'h0001);
      rd_reg(32'h5000_1030, d);
      chk("unmapped", d, 16'h0000);
      rd_reg(`LINE_CONDITION_STATUS_OFS, d);
      chk("lsr", d, 16'h00A5);
      wr_reg(`MODEM_IRQ_STATUS_OFS, 16'h000F);
      wr_reg(`MODEM_LINE_CONTROL_OFS, 16'h0000);
   endtask

   // counts and verdict
   task automatic close_out;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // hang guard
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         close_out();
      end
   end

   // main sequence
   initial begin
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      t_reset();
      t_bits();
      t_flow();
      t_modem();
      t_serial();
      t_irq();
      close_out();
   end
endmodule // uart_modem_ctrl_tb_top
`default_nettype wire
